// ==== bench/hdsl_hw_control_status_pins_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module hdsl_hw_control_status_pins_test;
  localparam int INACT = 20;
  localparam int SYNC = 40;
  logic aclk = 0, aresetn = 0, clk_en = 1, talk = 0;
  logic mode_strap_select_n = 1, write_strobe_n = 1, read_strobe_n = 1;
  logic act_request = 0, act_done = 0, act_fail = 0, deact_request = 0;
  logic sync_word_lost = 0, tx_frame_pulse = 0, interface_clock_raw = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire remote_tx_present, remote_data, hw_mode, inactive_flag, line_energy_lost;
  wire sync_loss_timeout, loop_analog_core, rx_data, interface_clock;
  wire ilt_tx_active, ilt_sync_word_en, irq;
  int n_fail = 0;
  int n_checks = 0;
  int k;
  logic [31:0] d;
  logic [1:0] r;
  hw_ctrl_pins #(.INACT_CYC(INACT), .SYNC_CYC(SYNC)) DUT (.*);
  remote_xcvr far_end (.aclk(aclk), .talk(talk), .remote_tx_present(remote_tx_present),
    .remote_data(remote_data));
  initial forever #2 aclk = ~aclk;
  task cyc(input int n); repeat (n) @(posedge aclk); endtask
  task chk(input [31:0] g, input [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus write: both channels offered, each dropped when taken
  task axw(input [4:0] a, input [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      cyc(1);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    cyc(1);
  endtask
  task axr(input [4:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      cyc(1);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    cyc(1);
  endtask
  task t_reset;
    axr(5'h00); chk(d, 32'h0);
    axr(5'h0C); chk(d, 32'h0);
    axr(5'h10); chk(r, 32'h2);
    axw(5'h10, 32'h0); chk(r, 32'h2);
    chk(line_energy_lost, 1);
    // outside loopback the far end's bits pass with one cycle of delay
    repeat (4) begin
      d[0] = remote_data;
      cyc(1);
      chk(rx_data, d[0]);
    end
  endtask
  task t_mode;
    {mode_strap_select_n, write_strobe_n, read_strobe_n} <= 3'h0;
    cyc(5); chk(hw_mode, 1);
    for (int i = 0; i < 3; i++) begin
      {mode_strap_select_n, write_strobe_n, read_strobe_n} <= 3'h1 << i;
      cyc(5); chk(hw_mode, 0);
      {mode_strap_select_n, write_strobe_n, read_strobe_n} <= 3'h0;
      cyc(5); chk(hw_mode, 1);
    end
  endtask
  // full activation, then a deactivation that must wait for silence
  task t_deact;
    axw(5'h00, 32'h1); cyc(3);
    chk(inactive_flag, 1);
    talk <= 1; act_request <= 1; cyc(1);
    act_request <= 0; act_done <= 1; cyc(1);
    act_done <= 0; cyc(2);
    axr(5'h04); chk(d[4:1], 32'h4);
    axw(5'h0C, 32'h2); cyc(2); chk(irq, 1);
    deact_request <= 1; cyc(1);
    deact_request <= 0; cyc(INACT + 5);
    chk(inactive_flag, 0);
    talk <= 0; k = 0;
    do begin cyc(1); k++; end while (!inactive_flag && k < 100);
    chk(k >= INACT && k <= INACT + 4, 1);
    axw(5'h08, 32'h2); cyc(3); chk(irq, 0);
  endtask
  task t_fail;
    talk <= 1; act_request <= 1; cyc(1);
    act_request <= 0; act_fail <= 1; cyc(1);
    act_fail <= 0; cyc(4);
    chk(inactive_flag, 1);
    talk <= 0;
  endtask
  task t_sync;
    sync_word_lost <= 1; cyc(SYNC - 2);
    sync_word_lost <= 0; cyc(2); chk(sync_loss_timeout, 0);
    sync_word_lost <= 1; cyc(SYNC + 4); chk(sync_loss_timeout, 1);
    sync_word_lost <= 0;
  endtask
  task t_ilt;
    axw(5'h00, 32'h4); cyc(4);
    chk(ilt_tx_active, 1);
    chk(ilt_sync_word_en, 1);
    axr(5'h04); chk(d[4:1], 32'h2);
    axw(5'h00, 32'h0); cyc(4); chk(ilt_tx_active, 0);
    act_fail <= 1; cyc(1); act_fail <= 0; cyc(4);
    chk(line_energy_lost, 1);
  endtask
  task t_clk;
    tx_frame_pulse <= 1; interface_clock_raw <= 0;
    axw(5'h00, 32'h3); cyc(3); chk(interface_clock, 1);
    axw(5'h00, 32'h2); cyc(3); chk(interface_clock, 0);
  endtask
  task t_loop;
    axw(5'h00, 32'h9); cyc(4);
    chk(loop_analog_core, 1);
    chk(inactive_flag, 0);
    talk <= 1;
    repeat (8) begin cyc(1); chk(rx_data, 1); end
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(5); aresetn <= 1;
    t_reset(); t_mode(); t_deact(); t_fail();
    t_sync(); t_ilt(); t_clk(); t_loop();
    print_verdict();
  end
  initial begin
    #40000; n_fail++; print_verdict();
  end
endmodule
`default_nettype wire

// ==== bench/hw_ctrl_pins_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module hw_ctrl_pins_sva #(
  parameter [31:0] SYNC_CYC = 32'd40
) (
  // clock, reset
  input wire logic aclk,
  input wire logic aresetn,
  // straps and status
  input wire logic mode_strap_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic sync_word_lost,
  input wire logic hw_mode,
  input wire logic inactive_flag,
  input wire logic line_energy_lost,
  input wire logic sync_loss_timeout,
  input wire logic loop_analog_core,
  input wire logic rx_data,
  input wire logic ilt_tx_active,
  input wire logic ilt_sync_word_en,
  // bus
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] run_q;
  logic [31:0] lost_q;
  // all three straps low, as one signal for the delayed compare
  wire logic straps_low = !(mode_strap_select_n | write_strobe_n | read_strobe_n);
  // strap pipe is only judged once it has filled after reset
  always @(posedge aclk) begin
    if (!aresetn) run_q <= 2'h0;
    else if (run_q != 2'h3) run_q <= run_q + 2'h1;
  end
  // length of the current sync-loss run
  always @(posedge aclk) begin
    if (!aresetn || !sync_word_lost) lost_q <= 32'h0;
    else lost_q <= lost_q + 32'h1;
  end
  sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  mode_follow_a: assert property (run_q == 2'h3 |-> hw_mode == $past(straps_low, 3))
    else $error("hw_mode does not follow straps");
  loop_data_a: assert property (
    loop_analog_core && $past(loop_analog_core) |-> rx_data)
    else $error("remote data seen in loopback");
  flag_excl_a: assert property (!(inactive_flag && line_energy_lost))
    else $error("both inactive flags high");
  test_sync_a: assert property (ilt_tx_active == ilt_sync_word_en)
    else $error("test frames without sync word");
  sync_time_a: assert property ($rose(sync_loss_timeout) |-> lost_q >= SYNC_CYC)
    else $error("sync timeout too early");
  sync_late_a: assert property (lost_q == SYNC_CYC + 32'h2 |-> sync_loss_timeout)
    else $error("sync timeout missing");
  sync_drop_a: assert property (!sync_word_lost |-> ##2 !sync_loss_timeout)
    else $error("sync timeout held after loss ended");
  b_hold_a: assert property (b_wait |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
endmodule
bind hw_ctrl_pins hw_ctrl_pins_sva #(.SYNC_CYC(SYNC_CYC)) sva_i (.*);
`default_nettype wire

// ==== bench/remote_xcvr.sv ====
`timescale 1ns/1ps
`default_nettype none
module remote_xcvr (
  // bench control
  input wire logic aclk,
  input wire logic talk,
  // line side
  output logic remote_tx_present,
  output logic remote_data
);
  logic [3:0] pat_q = 4'h9;
  // pattern moves even when silent, so stale data never looks held
  always @(posedge aclk) begin
    pat_q <= {pat_q[2:0], pat_q[3] ^ pat_q[2]};
  end
  assign remote_tx_present = talk;
  assign remote_data = pat_q[0];
endmodule
`default_nettype wire

// ==== rtl/hw_ctrl_pins.v ====
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "hw_ctrl_regs.vh"
module hw_ctrl_pins #(
  parameter [31:0] INACT_CYC = `INACT_CYCLES,
  parameter [31:0] SYNC_CYC = `SYNC_LOSS_CYCLES
) (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // mode straps
  input wire mode_strap_select_n,
  input wire write_strobe_n,
  input wire read_strobe_n,
  // activation machine events and line inputs
  input wire act_request,
  input wire act_done,
  input wire act_fail,
  input wire deact_request,
  input wire remote_tx_present,
  input wire sync_word_lost,
  input wire tx_frame_pulse,
  input wire interface_clock_raw,
  input wire remote_data,
  // axi4-lite write address
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // status and line outputs
  output reg hw_mode,
  output reg inactive_flag,
  output reg line_energy_lost,
  output reg sync_loss_timeout,
  output reg loop_analog_core,
  output reg rx_data,
  output reg interface_clock,
  output reg ilt_tx_active,
  output reg ilt_sync_word_en,
  output reg irq
);

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  reg [2:0] strap_s1_q; // first stage, read only by second
  reg [2:0] strap_s2_q;
  reg ilt_s1_q; // test input sync chain
  reg ilt_s2_q;
  reg far_end_loopback_s1_q;
  reg far_end_loopback_s2_q;
  // declared here: its test bits feed the chains below
  reg [3:0] ctrl_q; // mode, repeater, test, loopback

  // two flops ahead of mode and state logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      strap_s1_q <= 3'h7;
      strap_s2_q <= 3'h7;
      ilt_s1_q <= 1'b0;
      ilt_s2_q <= 1'b0;
      far_end_loopback_s1_q <= 1'b0;
      far_end_loopback_s2_q <= 1'b0;
    end else if (clk_en) begin
      strap_s1_q <= {mode_strap_select_n, write_strobe_n, read_strobe_n};
      strap_s2_q <= strap_s1_q;
      ilt_s1_q <= ctrl_q[`CTRL_ILT];
      ilt_s2_q <= ilt_s1_q;
      far_end_loopback_s1_q <= ctrl_q[`CTRL_FAR_END_LOOPBACK];
      far_end_loopback_s2_q <= far_end_loopback_s1_q;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [3:0] irq_stat_q; // sticky events
  reg [3:0] irq_mask_q;
  reg [3:0] state_q; // activation state, one-hot
  reg [3:0] state_d;
  reg from_active_q; // deactivation began in active
  reg [31:0] inact_cnt_q; // quiet-line timer
  reg [31:0] sync_cnt_q; // sync-loss timer
  reg loop_q; // loopback latched
  wire co_mode = ctrl_q[`CTRL_CO_MODE];
  // hardware mode only while all straps low
  wire hw_sel = (strap_s2_q == 3'h0);

  // decode of a register offset, shared by read and write
  function is_reg;
    input [4:0] addr;
    input [4:0] off;
    begin
      is_reg = (addr[4:2] == off[4:2]);
    end
  endfunction

  // ------------------------------------------------------------
  // activation state machine
  // ------------------------------------------------------------
  // activation states, one-hot
  localparam [3:0] ST_INACTIVE = 4'h1;
  localparam [3:0] ST_ACTIVATING = 4'h2;
  localparam [3:0] ST_ACTIVE = 4'h4;
  localparam [3:0] ST_DEACT = 4'h8;
  // remote-site test may start activation; users must expect it
  wire start_req = act_request | (ilt_s2_q & ~co_mode) | loop_q;
  wire inact_done = (inact_cnt_q >= INACT_CYC - 32'h1);

  // next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_INACTIVE: begin
        if (start_req)
          state_d = ST_ACTIVATING;
      end
      ST_ACTIVATING: begin
        if (act_fail)
          state_d = ST_DEACT;
        else if (act_done)
          state_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (deact_request)
          state_d = ST_DEACT;
      end
      ST_DEACT: begin
        // failed activation skips the wait
        if (!from_active_q)
          state_d = ST_INACTIVE;
        else if (inact_done)
          state_d = ST_INACTIVE;
      end
      default: begin
        state_d = ST_INACTIVE;
      end
    endcase
  end

  // state, timers
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_INACTIVE;
      from_active_q <= 1'b0;
      inact_cnt_q <= 32'h0;
      sync_cnt_q <= 32'h0;
      loop_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_q == ST_ACTIVE && state_d == ST_DEACT)
        from_active_q <= 1'b1;
      else if (state_q == ST_ACTIVATING)
        from_active_q <= 1'b0;
      // timer restarts while remote still talks
      if (state_q != ST_DEACT || remote_tx_present)
        inact_cnt_q <= 32'h0;
      else if (!inact_done)
        inact_cnt_q <= inact_cnt_q + 32'h1;
      // continuous sync loss only; saturates so the flag stays up
      // for as long as the loss lasts, without wrapping
      if (!sync_word_lost)
        sync_cnt_q <= 32'h0;
      else if (sync_cnt_q != SYNC_CYC)
        sync_cnt_q <= sync_cnt_q + 32'h1;
      // loopback arms only from inactive in central office
      if (!far_end_loopback_s2_q || !co_mode)
        loop_q <= 1'b0;
      else if (state_q == ST_INACTIVE)
        loop_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // flags follow the state one cycle late, from flops only
  wire in_inactive = (state_q == ST_INACTIVE);
  wire [3:0] events = {sync_cnt_q == SYNC_CYC, in_inactive, state_q == ST_ACTIVE,
                       loop_q};

  // all outputs registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      hw_mode <= 1'b0;
      inactive_flag <= 1'b0;
      line_energy_lost <= 1'b0;
      sync_loss_timeout <= 1'b0;
      loop_analog_core <= 1'b0;
      rx_data <= 1'b0;
      interface_clock <= 1'b0;
      ilt_tx_active <= 1'b0;
      ilt_sync_word_en <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      hw_mode <= hw_sel;
      inactive_flag <= co_mode & in_inactive;
      line_energy_lost <= ~co_mode & in_inactive;
      sync_loss_timeout <= (sync_cnt_q == SYNC_CYC);
      loop_analog_core <= loop_q;
      // loopback forces rx_data high; remote data dropped
      rx_data <= loop_q ? 1'b1 : remote_data;
      // trade-off: repeater copies the frame pulse, no phase search
      // repeater only honoured in central office
      if (co_mode && ctrl_q[`CTRL_REPEATER_ENABLE_EN])
        interface_clock <= tx_frame_pulse;
      else
        interface_clock <= interface_clock_raw;
      ilt_tx_active <= ilt_s2_q;
      ilt_sync_word_en <= ilt_s2_q;
      // interrupt lags its status bit by one cycle
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  reg aw_hold_q; // write address taken
  reg w_hold_q; // write data taken
  reg [4:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_wr = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire [3:0] w1c = (do_wr && is_reg(aw_addr_q, `REG_IRQ_STAT) && w_strb_q[0]) ?
                   w_data_q[3:0] : 4'h0;

  // write path; sets win over clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      ctrl_q <= `CTRL_RESET;
      irq_mask_q <= `MASK_RESET;
      irq_stat_q <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      irq_stat_q <= (irq_stat_q & ~w1c) | events;
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // only lane 0 holds register bits; other lanes are ignored
        if (w_strb_q[0]) begin
          if (is_reg(aw_addr_q, `REG_CTRL))
            ctrl_q <= w_data_q[3:0];
          else if (is_reg(aw_addr_q, `REG_IRQ_MASK))
            irq_mask_q <= w_data_q[3:0];
          else if (!is_reg(aw_addr_q, `REG_IRQ_STAT) && !is_reg(aw_addr_q, `REG_STATUS))
            s_axi_bresp <= 2'h2; // unmapped: slverr
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: one cycle after address accepted
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        if (is_reg(s_axi_araddr, `REG_CTRL))
          s_axi_rdata <= {28'h0, ctrl_q};
        else if (is_reg(s_axi_araddr, `REG_STATUS))
          // status word: mode, timeout, loop, state, deact origin
          s_axi_rdata <= {24'h0, hw_mode, sync_loss_timeout, loop_q, state_q, from_active_q};
        else if (is_reg(s_axi_araddr, `REG_IRQ_STAT))
          s_axi_rdata <= {28'h0, irq_stat_q};
        else if (is_reg(s_axi_araddr, `REG_IRQ_MASK))
          s_axi_rdata <= {28'h0, irq_mask_q};
        else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/hw_ctrl_regs.vh ====
`ifndef HW_CTRL_REGS_VH
`define HW_CTRL_REGS_VH
// register byte offsets
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_IRQ_STAT 5'h08
`define REG_IRQ_MASK 5'h0C
// ctrl field positions
`define CTRL_CO_MODE 0
`define CTRL_REPEATER_ENABLE_EN 1
`define CTRL_ILT 2
`define CTRL_FAR_END_LOOPBACK 3
// reset values
`define CTRL_RESET 4'h0
`define MASK_RESET 4'h0
// timing: reference clock 250 MHz
`define CLK_HZ 250000000
`define INACT_DELAY_MS 1000
`define SYNC_LOSS_MS 2000
`define INACT_CYCLES (`CLK_HZ / 1000 * `INACT_DELAY_MS)
`define SYNC_LOSS_CYCLES (`CLK_HZ / 1000 * `SYNC_LOSS_MS)
// activation states (one-hot)
`define ST_INACTIVE 4'h1
`define ST_ACTIVATING 4'h2
`define ST_ACTIVE 4'h4
`define ST_DEACT 4'h8
`endif
